//--- rtl/pmr_pkg.sv
// Package for the programming-model register set.
// Assumes a single 40 MHz clock domain and an AHB-Lite register port.
package pmr_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] GPR_BASE_OFS   = 8'h00;
    localparam logic [7:0] PC_OFS         = 8'h20;
    localparam logic [7:0] ISP_OFS        = 8'h24;
    localparam logic [7:0] USP_OFS        = 8'h28;
    localparam logic [7:0] FP_OFS         = 8'h2C;
    localparam logic [7:0] SBASE_OFS      = 8'h30;
    localparam logic [7:0] ITB_OFS        = 8'h34;
    localparam logic [7:0] MDP_OFS        = 8'h38;
    localparam logic [7:0] PSW_OFS        = 8'h3C;
    localparam logic [7:0] EXEC_STAT_OFS  = 8'h40;
    // ==========================================================
    // Status word bit positions
    localparam int PSW_C = 0;
    localparam int PSW_T = 1;
    localparam int PSW_L = 2;
    localparam int PSW_F = 5;
    localparam int PSW_Z = 6;
    localparam int PSW_N = 7;
    localparam int PSW_U = 8;
    localparam int PSW_S = 9;
    localparam int PSW_P = 10;
    localparam int PSW_I = 11;
    // ==========================================================
    // Reset values
    localparam logic [31:0] REG_RST  = 32'h0000_0000;
    localparam logic [15:0] PSW_RST  = 16'h0000;
    localparam logic [15:0] MDP_RST  = 16'h0000;
    // ==========================================================
    // Operand sizes
    typedef enum logic [1:0] {
        PMR_SZ_BYTE = 2'h0,
        PMR_SZ_WORD = 2'h1,
        PMR_SZ_DWORD = 2'h2
    } pmr_size_t;
    // ==========================================================
    // Execution unit operations
    typedef enum logic [2:0] {
        PMR_OP_NONE  = 3'h0,
        PMR_OP_ADD   = 3'h1,
        PMR_OP_SUB   = 3'h2,
        PMR_OP_CMP   = 3'h3,
        PMR_OP_FCMP  = 3'h4,
        PMR_OP_PUSH  = 3'h5,
        PMR_OP_POP   = 3'h6
    } pmr_op_t;
endpackage

//--- rtl/pmr_regs.sv
// Processor programming-model registers with execution port and AHB-Lite window.
// Assumes the execution unit issues one operation per cycle; the bus has lower priority.
`timescale 1ns/10ps
module pmr_regs (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Execution unit: general register access
    input  wire logic [2:0]  gpr_rd_idx,
    output logic      [31:0] gpr_rd_data,
    input  wire logic        gpr_wr_en,
    input  wire logic [2:0]  gpr_wr_idx,
    input  wire logic [1:0]  gpr_wr_size,
    input  wire logic [31:0] gpr_wr_data,
    // Execution unit: operation and flags
    input  wire logic [2:0]  op,
    input  wire logic [1:0]  op_size,
    input  wire logic [31:0] op_a,
    input  wire logic [31:0] op_b,
    input  wire logic        use_carry,
    output logic      [31:0] op_result,
    output logic      [31:0] stack_addr,
    // Execution unit: dedicated register control
    input  wire logic        instr_start,
    input  wire logic [31:0] instr_addr,
    input  wire logic        instr_done,
    input  wire logic        frame_load,
    input  wire logic [31:0] frame_value,
    input  wire logic        trap_entry,
    input  wire logic        trace_taken,
    input  wire logic        priv_instr,
    input  wire logic        irq_req,
    input  wire logic        nmi_req,
    // Execution unit: status out
    output logic             priv_fault,
    output logic             trace_trap,
    output logic             irq_accept,
    output logic      [31:0] program_counter,
    output logic      [15:0] processor_status_word
);
    // ==========================================================
    // Register storage
    logic [31:0] gpr_q [8];
    logic [31:0] pc_q, isp_q, usp_q, fp_q, sb_q, itb_q;
    logic [15:0] mdp_q, psw_q;
    logic        trap_q, fault_q;

    // Size mask for partial operands
    function automatic logic [31:0] size_mask(input logic [1:0] sz);
        return (sz == 2'(pmr_pkg::PMR_SZ_BYTE)) ? 32'h0000_00FF :
               (sz == 2'(pmr_pkg::PMR_SZ_WORD)) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    endfunction
    function automatic logic [31:0] size_len(input logic [1:0] sz);
        return (sz == 2'(pmr_pkg::PMR_SZ_BYTE)) ? 32'h0000_0001 :
               (sz == 2'(pmr_pkg::PMR_SZ_WORD)) ? 32'h0000_0002 : 32'h0000_0004;
    endfunction
    function automatic logic [3:0] sign_pos(input logic [1:0] sz);
        return (sz == 2'(pmr_pkg::PMR_SZ_BYTE)) ? 4'h0 :
               (sz == 2'(pmr_pkg::PMR_SZ_WORD)) ? 4'h1 : 4'h3;
    endfunction

    // ==========================================================
    // Bus address phase capture
    logic        ph_wr_q, ph_rd_q;
    logic [7:0]  ph_addr_q;
    wire         bus_go = hsel & hready & htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_q   <= 1'b0;
            ph_rd_q   <= 1'b0;
            ph_addr_q <= 8'h00;
        end else if (hready) begin
            ph_wr_q   <= bus_go & hwrite;
            ph_rd_q   <= bus_go & ~hwrite;
            ph_addr_q <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ==========================================================
    // Stack pointer selection and adjust
    wire         sel_user  = psw_q[pmr_pkg::PSW_S];
    wire [31:0]  sp_act    = sel_user ? usp_q : isp_q;
    wire [31:0]  len       = size_len(op_size);
    wire         is_push   = op == 3'(pmr_pkg::PMR_OP_PUSH);
    wire         is_pop    = op == 3'(pmr_pkg::PMR_OP_POP);
    wire [31:0]  sp_dec    = sp_act - len;
    wire [31:0]  sp_inc    = sp_act + len;
    assign stack_addr      = is_push ? sp_dec : sp_act;
    wire         sp_upd    = is_push | is_pop;
    wire [31:0]  sp_new    = is_push ? sp_dec : sp_inc;

    // ==========================================================
    // Arithmetic and compare flags
    wire [31:0]  msk       = size_mask(op_size);
    wire [31:0]  am        = op_a & msk;
    wire [31:0]  bm        = op_b & msk;
    wire         cin       = use_carry & psw_q[pmr_pkg::PSW_C];
    wire         is_add    = op == 3'(pmr_pkg::PMR_OP_ADD);
    wire         is_sub    = op == 3'(pmr_pkg::PMR_OP_SUB);
    wire         is_cmp    = op == 3'(pmr_pkg::PMR_OP_CMP);
    wire         is_fcmp   = op == 3'(pmr_pkg::PMR_OP_FCMP);
    wire [32:0]  sum       = {1'b0, bm} + {1'b0, am} + {32'h0, cin};
    wire [32:0]  dif       = {1'b0, bm} - {1'b0, am} - {32'h0, cin};
    wire [31:0]  res       = (is_add ? sum[31:0] : dif[31:0]) & msk;
    wire [4:0]   top       = (op_size == 2'(pmr_pkg::PMR_SZ_BYTE)) ? 5'd7 :
                             (op_size == 2'(pmr_pkg::PMR_SZ_WORD)) ? 5'd15 : 5'd31;
    wire         sa        = am[top];
    wire         sbb       = bm[top];
    wire         sr        = res[top];
    wire         carry     = (op_size == 2'(pmr_pkg::PMR_SZ_BYTE)) ?
                             (is_add ? sum[8] : dif[8]) :
                             (op_size == 2'(pmr_pkg::PMR_SZ_WORD)) ?
                             (is_add ? sum[16] : dif[16]) :
                             (is_add ? sum[32] : dif[32]);
    wire         ovf       = is_add ? (sa == sbb) & (sr != sbb)
                                    : (sa != sbb) & (sr != sbb);
    wire         lt_u      = bm < am;
    wire         lt_s      = (sbb != sa) ? sbb : lt_u;
    assign op_result       = res;

    // ==========================================================
    // Status word next value
    wire         sup       = ~psw_q[pmr_pkg::PSW_U];
    wire         bus_psw   = ph_wr_q & (ph_addr_q == pmr_pkg::PSW_OFS);
    logic [15:0] psw_d;
    always_comb begin
        psw_d = psw_q;
        if (bus_psw) begin
            psw_d[7:0] = hwdata[7:0];
            if (sup)
                psw_d[15:8] = hwdata[15:8];
        end
        if (is_add | is_sub) begin
            psw_d[pmr_pkg::PSW_C] = carry;
            psw_d[pmr_pkg::PSW_F] = ovf;
        end
        if (is_cmp) begin
            psw_d[pmr_pkg::PSW_L] = lt_u;
            psw_d[pmr_pkg::PSW_Z] = bm == am;
            psw_d[pmr_pkg::PSW_N] = lt_s;
        end
        if (is_fcmp)
            psw_d[pmr_pkg::PSW_L] = 1'b0;
        if (instr_start)
            psw_d[pmr_pkg::PSW_P] = psw_q[pmr_pkg::PSW_T];
        if (trace_taken)
            psw_d[pmr_pkg::PSW_P] = 1'b0;
        if (trap_entry)
            psw_d[pmr_pkg::PSW_S] = 1'b0;
    end

    // ==========================================================
    // Register updates
    wire bus_gpr = ph_wr_q & (ph_addr_q[7:5] == 3'h0);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 8; i++)
                gpr_q[i] <= pmr_pkg::REG_RST;
        end else if (gpr_wr_en) begin
            gpr_q[gpr_wr_idx] <= (gpr_q[gpr_wr_idx] & ~size_mask(gpr_wr_size))
                               | (gpr_wr_data & size_mask(gpr_wr_size));
        end else if (bus_gpr) begin
            gpr_q[ph_addr_q[4:2]] <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_q  <= pmr_pkg::REG_RST;
            isp_q <= pmr_pkg::REG_RST;
            usp_q <= pmr_pkg::REG_RST;
            fp_q  <= pmr_pkg::REG_RST;
            sb_q  <= pmr_pkg::REG_RST;
            itb_q <= pmr_pkg::REG_RST;
            mdp_q <= pmr_pkg::MDP_RST;
            psw_q <= pmr_pkg::PSW_RST;
        end else begin
            psw_q <= psw_d;
            if (instr_start)
                pc_q <= instr_addr;
            else if (ph_wr_q && ph_addr_q == pmr_pkg::PC_OFS)
                pc_q <= hwdata;
            if (sp_upd && !sel_user)
                isp_q <= sp_new;
            else if (ph_wr_q && ph_addr_q == pmr_pkg::ISP_OFS)
                isp_q <= hwdata;
            if (sp_upd && sel_user)
                usp_q <= sp_new;
            else if (ph_wr_q && ph_addr_q == pmr_pkg::USP_OFS)
                usp_q <= hwdata;
            if (frame_load)
                fp_q <= frame_value;
            else if (ph_wr_q && ph_addr_q == pmr_pkg::FP_OFS)
                fp_q <= hwdata;
            if (ph_wr_q && ph_addr_q == pmr_pkg::SBASE_OFS)
                sb_q <= hwdata;
            if (ph_wr_q && ph_addr_q == pmr_pkg::ITB_OFS)
                itb_q <= hwdata;
            if (ph_wr_q && ph_addr_q == pmr_pkg::MDP_OFS)
                mdp_q <= hwdata[15:0];
        end
    end

    // ==========================================================
    // Trace, privilege and interrupt gating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_q  <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            trap_q  <= instr_done & psw_q[pmr_pkg::PSW_P] & ~trace_taken;
            fault_q <= priv_instr & psw_q[pmr_pkg::PSW_U];
        end
    end
    assign trace_trap  = trap_q;
    assign priv_fault  = fault_q;
    assign irq_accept  = nmi_req | (irq_req & psw_q[pmr_pkg::PSW_I]);
    assign program_counter       = pc_q;
    assign processor_status_word = psw_q;

    // ==========================================================
    // Read paths, with write bypass for the execution port
    wire bypass = gpr_wr_en & (gpr_wr_idx == gpr_rd_idx);
    assign gpr_rd_data = bypass ? ((gpr_q[gpr_rd_idx] & ~size_mask(gpr_wr_size))
                                 | (gpr_wr_data & size_mask(gpr_wr_size)))
                                : gpr_q[gpr_rd_idx];
    logic [31:0] rd_mux;
    always_comb begin
        unique case (ph_addr_q)
            pmr_pkg::PC_OFS:        rd_mux = pc_q;
            pmr_pkg::ISP_OFS:       rd_mux = isp_q;
            pmr_pkg::USP_OFS:       rd_mux = usp_q;
            pmr_pkg::FP_OFS:        rd_mux = fp_q;
            pmr_pkg::SBASE_OFS:     rd_mux = sb_q;
            pmr_pkg::ITB_OFS:       rd_mux = itb_q;
            pmr_pkg::MDP_OFS:       rd_mux = {16'h0000, mdp_q};
            pmr_pkg::PSW_OFS:       rd_mux = {16'h0000, psw_q};
            pmr_pkg::EXEC_STAT_OFS: rd_mux = {29'h0, irq_accept, trap_q, fault_q};
            default:                rd_mux = (ph_addr_q[7:5] == 3'h0) ?
                                             gpr_q[ph_addr_q[4:2]] : 32'h0000_0000;
        endcase
    end
    assign hrdata = ph_rd_q ? rd_mux : 32'h0000_0000;

    // ==========================================================
    // Checks
    property p_push_dec;
        @(posedge hclk) disable iff (!hresetn)
        is_push && !sel_user && !trap_entry |=> isp_q == $past(isp_q) - $past(len);
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push did not decrement");
    property p_pop_inc;
        @(posedge hclk) disable iff (!hresetn)
        is_pop && sel_user |=> usp_q == $past(usp_q) + $past(len);
    endproperty
    a_pop_inc: assert property (p_pop_inc) else $error("pop did not increment");
    property p_trap_s;
        @(posedge hclk) disable iff (!hresetn)
        trap_entry |=> !psw_q[pmr_pkg::PSW_S];
    endproperty
    a_trap_s: assert property (p_trap_s) else $error("stack select not cleared");
    property p_user_hi;
        @(posedge hclk) disable iff (!hresetn)
        bus_psw && psw_q[pmr_pkg::PSW_U] && !trap_entry && !instr_start && !trace_taken
        |=> psw_q[15:8] == $past(psw_q[15:8]);
    endproperty
    a_user_hi: assert property (p_user_hi) else $error("user changed high status");
    property p_zero;
        @(posedge hclk) disable iff (!hresetn)
        is_cmp && !bus_psw |=> psw_q[pmr_pkg::PSW_Z] == ($past(bm) == $past(am));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_fcmp;
        @(posedge hclk) disable iff (!hresetn)
        is_fcmp && !bus_psw |=> !psw_q[pmr_pkg::PSW_L];
    endproperty
    a_fcmp: assert property (p_fcmp) else $error("float compare left lower flag");
    property p_fault;
        @(posedge hclk) disable iff (!hresetn)
        priv_instr && !psw_q[pmr_pkg::PSW_U] |=> !priv_fault;
    endproperty
    a_fault: assert property (p_fault) else $error("supervisor refused");
    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        irq_accept |-> nmi_req || psw_q[pmr_pkg::PSW_I];
    endproperty
    a_irq: assert property (p_irq) else $error("masked interrupt accepted");
endmodule // pmr_regs

//--- tb/pmr_regs_tb_top.sv
// Self-checking bench for the programming-model register set.
// Assumes the register set alone, driven over AHB-Lite and its execution port.
`timescale 1ns/10ps
module pmr_regs_tb_top;
    // ==========================================
    // Signals
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdat_q, gpr_rd_data, op_result, stack_addr, program_counter;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hready, hresp, priv_fault, trace_trap, irq_accept;
    logic [2:0]  gpr_rd_idx = 3'h0;
    logic [2:0]  gpr_wr_idx = 3'h0;
    logic [2:0]  op = 3'h0;
    logic [1:0]  gpr_wr_size = 2'h0;
    logic [1:0]  op_size = 2'h0;
    logic [31:0] gpr_wr_data = 32'h0;
    logic [31:0] op_a = 32'h0;
    logic [31:0] op_b = 32'h0;
    logic [31:0] instr_addr = 32'h0;
    logic [31:0] frame_value = 32'h0;
    logic        gpr_wr_en = 1'b0, use_carry = 1'b0, instr_start = 1'b0, instr_done = 1'b0;
    logic        frame_load = 1'b0, trap_entry = 1'b0, trace_taken = 1'b0, priv_instr = 1'b0;
    logic        irq_req = 1'b0, nmi_req = 1'b0;
    logic [15:0] processor_status_word;
    int          err_count = 0;
    int          n_tests = 0;

    always #12.5 hclk = ~hclk;
    always @(posedge hclk) rdat_q <= hrdata;

    pmr_regs pmr_regs_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .gpr_rd_idx(gpr_rd_idx), .gpr_rd_data(gpr_rd_data), .gpr_wr_en(gpr_wr_en),
        .gpr_wr_idx(gpr_wr_idx), .gpr_wr_size(gpr_wr_size), .gpr_wr_data(gpr_wr_data),
        .op(op), .op_size(op_size), .op_a(op_a), .op_b(op_b), .use_carry(use_carry),
        .op_result(op_result), .stack_addr(stack_addr), .instr_start(instr_start),
        .instr_addr(instr_addr), .instr_done(instr_done), .frame_load(frame_load),
        .frame_value(frame_value), .trap_entry(trap_entry), .trace_taken(trace_taken),
        .priv_instr(priv_instr), .irq_req(irq_req), .nmi_req(nmi_req),
        .priv_fault(priv_fault), .trace_trap(trace_trap), .irq_accept(irq_accept),
        .program_counter(program_counter), .processor_status_word(processor_status_word)
    );

    // ==========================================
    // Checking and bus tasks
    task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            err_count++;
            finish_test;
        end
    endtask

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        #1 r = rdat_q;
    endtask

    function automatic logic [31:0] ofs(input logic [7:0] o);
        return {24'h0, o};
    endfunction

    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, r, exp);
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task exec(input logic [2:0] o, input logic [1:0] sz, input logic [31:0] a,
              input logic [31:0] b, input logic uc, output logic [31:0] res,
              output logic [31:0] sa);
        @(posedge hclk);
        op        <= o;
        op_size   <= sz;
        op_a      <= a;
        op_b      <= b;
        use_carry <= uc;
        @(negedge hclk);
        res = op_result;
        sa = stack_addr;
        @(posedge hclk);
        op <= pmr_pkg::PMR_OP_NONE;
        @(negedge hclk);
    endtask

    task cmp1(input logic [31:0] a, input logic [31:0] b, input logic [2:0] e);
        logic [31:0] r, s;
        exec(pmr_pkg::PMR_OP_CMP, pmr_pkg::PMR_SZ_DWORD, a, b, 1'b0, r, s);
        chk("nzl", {29'h0, processor_status_word[pmr_pkg::PSW_N],
            processor_status_word[pmr_pkg::PSW_Z], processor_status_word[pmr_pkg::PSW_L]},
            {29'h0, e});
    endtask

    // ==========================================
    // Scenarios
    task t_regs;
        for (int i = 0; i < 15; i++) begin
            rd("reset value", 32'(i * 4), 32'h0);
            wr(32'(i * 4), 32'hFFFFFFFF);
            rd("width", 32'(i * 4), (i == 14) ? 32'h0000FFFF : 32'hFFFFFFFF);
        end
        wr(32'h80, 32'hFFFFFFFF);
        rd("unmapped", 32'h80, 32'h0);
    endtask

    task t_gpr;
        wr(32'h08, 32'h11223344);
        @(posedge hclk);
        gpr_wr_en   <= 1'b1;
        gpr_wr_idx  <= 3'h2;
        gpr_rd_idx  <= 3'h2;
        gpr_wr_size <= pmr_pkg::PMR_SZ_BYTE;
        gpr_wr_data <= 32'hFFFFFFAA;
        @(negedge hclk);
        chk("gpr bypass", gpr_rd_data, 32'h112233AA);
        @(posedge hclk);
        gpr_wr_size <= pmr_pkg::PMR_SZ_WORD;
        gpr_wr_data <= 32'hFFFFBEEF;
        @(posedge hclk);
        gpr_wr_en <= 1'b0;
        rd("gpr word", 32'h08, 32'h1122BEEF);
    endtask

    task t_stack;
        logic [31:0] r, s;
        wr(ofs(pmr_pkg::ISP_OFS), 32'h100);
        wr(ofs(pmr_pkg::USP_OFS), 32'h200);
        exec(pmr_pkg::PMR_OP_PUSH, pmr_pkg::PMR_SZ_DWORD, 32'h0, 32'h0, 1'b0, r, s);
        chk("push addr", s, 32'hFC);
        rd("isp", ofs(pmr_pkg::ISP_OFS), 32'hFC);
        wr(ofs(pmr_pkg::PSW_OFS), 32'h0200);
        exec(pmr_pkg::PMR_OP_POP, pmr_pkg::PMR_SZ_WORD, 32'h0, 32'h0, 1'b0, r, s);
        chk("pop addr", s, 32'h200);
        rd("usp", ofs(pmr_pkg::USP_OFS), 32'h202);
        exec(pmr_pkg::PMR_OP_PUSH, pmr_pkg::PMR_SZ_BYTE, 32'h0, 32'h0, 1'b0, r, s);
        chk("push byte", s, 32'h201);
        @(posedge hclk);
        trap_entry <= 1'b1;
        @(posedge hclk);
        trap_entry <= 1'b0;
        @(negedge hclk);
        chk("stack sel", {31'h0, processor_status_word[pmr_pkg::PSW_S]}, 32'h0);
        exec(pmr_pkg::PMR_OP_NONE, pmr_pkg::PMR_SZ_DWORD, 32'h0, 32'h0, 1'b0, r, s);
        chk("active sp", s, 32'hFC);
    endtask

    task t_arith;
        logic [31:0] r, s;
        exec(pmr_pkg::PMR_OP_ADD, pmr_pkg::PMR_SZ_DWORD, 32'hFFFFFFFF, 32'h1, 1'b0, r, s);
        chk("add", r, 32'h0);
        chk("carry", {30'h0, processor_status_word[5], processor_status_word[0]}, 32'h1);
        exec(pmr_pkg::PMR_OP_ADD, pmr_pkg::PMR_SZ_DWORD, 32'h7FFFFFFF, 32'h1, 1'b0, r, s);
        chk("ovf", {30'h0, processor_status_word[5], processor_status_word[0]}, 32'h2);
        exec(pmr_pkg::PMR_OP_SUB, pmr_pkg::PMR_SZ_DWORD, 32'h2, 32'h1, 1'b0, r, s);
        chk("sub", r, 32'hFFFFFFFF);
        chk("borrow", {31'h0, processor_status_word[pmr_pkg::PSW_C]}, 32'h1);
        exec(pmr_pkg::PMR_OP_ADD, pmr_pkg::PMR_SZ_DWORD, 32'h1, 32'h1, 1'b1, r, s);
        chk("add_with_carry_op", r, 32'h3);
        exec(pmr_pkg::PMR_OP_ADD, pmr_pkg::PMR_SZ_BYTE, 32'hFF, 32'h1, 1'b0, r, s);
        chk("byte carry", {31'h0, processor_status_word[pmr_pkg::PSW_C]}, 32'h1);
    endtask

    task t_cmp;
        logic [31:0] r, s;
        cmp1(32'h5, 32'h3, 3'h5);
        cmp1(32'hFFFFFFFF, 32'h1, 3'h1);
        cmp1(32'h1, 32'hFFFFFFFF, 3'h4);
        cmp1(32'h7, 32'h7, 3'h2);
        cmp1(32'h5, 32'h3, 3'h5);
        exec(pmr_pkg::PMR_OP_FCMP, pmr_pkg::PMR_SZ_DWORD, 32'h5, 32'h3, 1'b0, r, s);
        chk("fcmp", {31'h0, processor_status_word[pmr_pkg::PSW_L]}, 32'h0);
    endtask

    task t_trace;
        wr(ofs(pmr_pkg::PSW_OFS), 32'h0002);
        @(posedge hclk);
        instr_start <= 1'b1;
        instr_addr  <= 32'h400;
        @(posedge hclk);
        instr_start <= 1'b0;
        instr_done  <= 1'b1;
        @(negedge hclk);
        chk("pc", program_counter, 32'h400);
        chk("pending", {31'h0, processor_status_word[pmr_pkg::PSW_P]}, 32'h1);
        @(posedge hclk);
        instr_done  <= 1'b0;
        trace_taken <= 1'b1;
        @(negedge hclk);
        chk("trace", {31'h0, trace_trap}, 32'h1);
        @(posedge hclk);
        trace_taken <= 1'b0;
        instr_done  <= 1'b1;
        @(posedge hclk);
        instr_done <= 1'b0;
        @(negedge hclk);
        chk("trace once", {31'h0, trace_trap}, 32'h0);
    endtask

    task t_irq;
        wr(ofs(pmr_pkg::PSW_OFS), 32'h0000);
        @(posedge hclk);
        irq_req <= 1'b1;
        @(negedge hclk);
        chk("irq masked", {31'h0, irq_accept}, 32'h0);
        @(posedge hclk);
        nmi_req <= 1'b1;
        @(negedge hclk);
        chk("nmi", {31'h0, irq_accept}, 32'h1);
        rd("exec status", ofs(pmr_pkg::EXEC_STAT_OFS), 32'h4);
        @(posedge hclk);
        nmi_req <= 1'b0;
        wr(ofs(pmr_pkg::PSW_OFS), 32'h0800);
        @(negedge hclk);
        chk("irq open", {31'h0, irq_accept}, 32'h1);
        @(posedge hclk);
        irq_req <= 1'b0;
    endtask

    task t_user;
        @(posedge hclk);
        frame_load  <= 1'b1;
        frame_value <= 32'h3000;
        priv_instr  <= 1'b1;
        @(posedge hclk);
        frame_load <= 1'b0;
        priv_instr <= 1'b0;
        @(negedge hclk);
        chk("no fault", {31'h0, priv_fault}, 32'h0);
        rd("fp", ofs(pmr_pkg::FP_OFS), 32'h3000);
        wr(ofs(pmr_pkg::PSW_OFS), 32'h0100);
        wr(ofs(pmr_pkg::PSW_OFS), 32'h0FE1);
        rd("psw user", ofs(pmr_pkg::PSW_OFS), 32'h01E1);
        @(posedge hclk);
        priv_instr <= 1'b1;
        @(posedge hclk);
        priv_instr <= 1'b0;
        @(negedge hclk);
        chk("fault", {31'h0, priv_fault}, 32'h1);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_gpr;
        t_stack;
        t_arith;
        t_cmp;
        t_trace;
        t_irq;
        t_user;
        finish_test;
    end
endmodule // pmr_regs_tb_top
